// >>> rtl/ird_regs.svh
`ifndef IRD_REGS_SVH
`define IRD_REGS_SVH

// Baud clock periods per decoded bit.
`define IRD_BIT_TICKS      5'd16
// Last value of the local counter.
`define IRD_CNT_MAX        4'hf
// Count at which the rebuilt receive line is updated.
`define IRD_CNT_UPDATE     4'h8
// Count at which the window for the next pulse opens.
`define IRD_CNT_WINDOW     4'hc
// Idle level of the rebuilt receive line.
`define IRD_RX_IDLE        1'b1
// FIFO geometry.
`define IRD_FIFO_WIDTH     1
`define IRD_FIFO_DEPTH     32

`endif

// >>> rtl/ird_pkg.sv
package ird_pkg;

   typedef enum logic [1:0] {
      IRD_IDLE,
      IRD_WAIT,
      IRD_OPEN
   } ird_state_t;

endpackage

// >>> rtl/ird_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module ird_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_comb begin
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/ird_decoder.sv
// Function
// - Decode infrared pin input into a serial stream for the UART receiver.
// - All timing comes from the UART baud rate clock enable.
// - Each decoded bit spans sixteen baud clock periods.
// - When enabled, pin feeds decoder; UART receive line is driven internally.
// - Local baud counter runs zero to fifteen, timing output and window.
// - Rebuilt receive line lags the infrared stream by eight baud periods.
// - Falling edge of infrared input in idle or inside the window resets the local counter to zero.
// - At count eight the receive output takes the decoded bit.
// - At count twelve the window for the next pulse opens.
`timescale 1ns/1ps
`default_nettype none
`include "ird_regs.svh"

module ird_decoder (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Control
   input  wire logic decode_enable,
   input  wire logic baud_tick,
   // Infrared pin input
   input  wire logic infrared_receive_input,
   // To the UART receiver
   output logic      uart_rx,
   output logic      bit_valid,
   output logic      bit_data,
   input  wire logic bit_ready,
   output logic      overrun
);

   import ird_pkg::*;

   // Synchroniser and edge history.
   logic             pin_meta;
   logic             pin_sync;
   logic             pin_prev;
   logic             fall;

   // Decoder state.
   ird_state_t       state;
   ird_state_t       next_state;
   logic [3:0]       cnt;
   logic [3:0]       next_cnt;
   logic             pulse_seen;
   logic             next_pulse_seen;
   logic             rx_line;
   logic             next_rx_line;
   logic             push;
   logic             next_push;
   logic             push_data;
   logic             next_push_data;
   logic             fifo_ready;
   logic             fifo_valid;
   logic             fifo_data;
   logic             next_uart_rx;
   logic             next_bit_valid;
   logic             next_bit_data;
   logic             next_overrun;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         pin_prev <= 1'b1;
      end else begin
         pin_meta <= infrared_receive_input;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign fall = decode_enable && pin_prev && !pin_sync;

   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_pulse_seen = pulse_seen;
      next_rx_line    = rx_line;
      next_push       = 1'b0;
      next_push_data  = push_data;
      case (state)
         IRD_IDLE: begin
            if (fall) begin
               next_cnt        = 4'h0;
               next_pulse_seen = 1'b1;
               next_state      = IRD_WAIT;
            end
         end
         IRD_WAIT: begin
            if (baud_tick) begin
               next_cnt = (cnt == `IRD_CNT_MAX) ? 4'h0 : cnt + 4'h1;
               if (cnt + 4'h1 == `IRD_CNT_UPDATE) begin
                  next_rx_line    = !pulse_seen;
                  next_push       = 1'b1;
                  next_push_data  = !pulse_seen;
                  next_pulse_seen = 1'b0;
               end
               if (cnt + 4'h1 == `IRD_CNT_WINDOW) begin
                  next_state = IRD_OPEN;
               end
            end
         end
         IRD_OPEN: begin
            if (fall) begin
               next_cnt        = 4'h0;
               next_pulse_seen = 1'b1;
               next_state      = IRD_WAIT;
            end else if (baud_tick) begin
               next_cnt = (cnt == `IRD_CNT_MAX) ? 4'h0 : cnt + 4'h1;
               // window spans twelve through zero
               // The window stays open through count zero, because the synchroniser
               // delay makes an on-time pulse arrive just after the counter wraps.
               if (cnt == 4'h0) begin
                  next_state = IRD_WAIT;
               end
            end
         end
         default: begin
            next_state = IRD_IDLE;
         end
      endcase
      if (!decode_enable) begin
         next_state      = IRD_IDLE;
         next_cnt        = 4'h0;
         next_pulse_seen = 1'b0;
         next_push       = 1'b0;
         next_rx_line    = `IRD_RX_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state      <= IRD_IDLE;
         cnt        <= 4'h0;
         pulse_seen <= 1'b0;
         rx_line    <= `IRD_RX_IDLE;
         push       <= 1'b0;
         push_data  <= 1'b1;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         pulse_seen <= next_pulse_seen;
         rx_line    <= next_rx_line;
         push       <= next_push;
         push_data  <= next_push_data;
      end
   end

   // Decoded bits queue here, up to 32, so a slow UART can stall without losing bits.
   ird_fifo #(
      .WIDTH (`IRD_FIFO_WIDTH),
      .DEPTH (`IRD_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_data   (push_data),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (bit_ready && !bit_valid)
   );

   always_comb begin
      next_uart_rx   = rx_line;
      next_bit_valid = bit_valid && !bit_ready;
      next_bit_data  = bit_data;
      if (fifo_valid && bit_ready && !bit_valid) begin
         next_bit_valid = 1'b1;
         next_bit_data  = fifo_data;
      end
      // A full queue drops the new bit; the sticky flag tells the UART.
      next_overrun = overrun || (push && !fifo_ready);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         uart_rx   <= `IRD_RX_IDLE;
         bit_valid <= 1'b0;
         bit_data  <= 1'b1;
         overrun   <= 1'b0;
      end else begin
         uart_rx   <= next_uart_rx;
         bit_valid <= next_bit_valid;
         bit_data  <= next_bit_data;
         overrun   <= next_overrun;
      end
   end

   // Helper counting ticks since the last accepted edge; edges before the window opens are ignored.
   logic [4:0] tick_gap;
   always_ff @(posedge sys_clk) begin
      if (rst || (fall && state != IRD_WAIT)) begin
         tick_gap <= 5'd0;
      end else if (baud_tick && tick_gap != 5'd31) begin
         tick_gap <= tick_gap + 5'd1;
      end
   end

   sequence edge_seen_s;
      fall && state != IRD_WAIT;
   endsequence

   sequence cnt_cleared_s;
      cnt == 4'h0;
   endsequence

   edge_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
      edge_seen_s |=> cnt_cleared_s)
      else $error("Counter not cleared after falling edge.");

   cnt_range_a: assert property (@(posedge sys_clk) disable iff (rst)
      (cnt == `IRD_CNT_MAX && baud_tick && !fall && decode_enable) |=> cnt == 4'h0)
      else $error("Counter did not wrap from fifteen to zero.");

   update_eight_a: assert property (@(posedge sys_clk) disable iff (rst)
      push |-> $past(cnt) == 4'h7 && cnt == `IRD_CNT_UPDATE)
      else $error("Bit pushed away from count eight.");

   window_twelve_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state == IRD_OPEN && $past(state) == IRD_WAIT) |-> cnt == `IRD_CNT_WINDOW)
      else $error("Window opened at wrong count.");

   window_closed_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state == IRD_WAIT) |-> cnt < `IRD_CNT_WINDOW)
      else $error("Window did not open at twelve.");

   pulse_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      push && $past(pulse_seen) |-> push_data == 1'b0)
      else $error("Pulse did not decode as zero.");

   lag_eight_a: assert property (@(posedge sys_clk) disable iff (rst)
      push && $past(pulse_seen) |-> tick_gap == 5'd8)
      else $error("Receive update not eight ticks after edge.");

   idle_high_a: assert property (@(posedge sys_clk) disable iff (rst)
      !decode_enable |=> ##1 uart_rx == 1'b1)
      else $error("Receive line not high while disabled.");

   uart_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
      1'b1 |=> uart_rx == $past(rx_line))
      else $error("Receive output does not follow decoder.");

endmodule

`default_nettype wire

// >>> dv/ird_ir_model.sv
`timescale 1ns/1ps
`default_nettype none

module ird_ir_model (
   // Clock and baud timing
   input  wire logic sys_clk,
   input  wire logic baud_tick,
   // Infrared pin, driven by the transceiver
   output var logic  infrared_receive_input
);
   initial infrared_receive_input = 1'b1;

   // pulse width
   // A four tick pulse at this baud rate is 1.6 us, above the shortest legal pulse.
   task automatic send_bit(input logic b);
      int i;
      for (i = 0; i < 16; i++) begin
         @(posedge sys_clk iff baud_tick);
         infrared_receive_input <= (b === 1'b0 && i < 4) ? 1'b0 : 1'b1;
      end
   endtask
endmodule

`default_nettype wire

// >>> dv/test_infrared_receive_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module test_infrared_receive_decoder;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       decode_enable = 1'b1;
   logic       baud_tick = 1'b0;
   logic       bit_ready = 1'b1;
   logic       pin;
   logic       uart_rx;
   logic       bit_valid;
   logic       bit_data;
   logic       overrun;
   logic [1:0] div = 2'h0;
   logic       got[$];
   int         num_errors = 0;
   int         checks_done = 0;

   always #50 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      div <= div + 2'h1;
      baud_tick <= (div == 2'h3);
      if (bit_valid === 1'b1 && bit_ready === 1'b1)
         got.push_back(bit_data);
   end

   ird_ir_model ird_ir_model_i (
      .sys_clk               (sys_clk),
      .baud_tick             (baud_tick),
      .infrared_receive_input(pin)
   );

   ird_decoder ird_decoder_i (
      .sys_clk               (sys_clk),
      .rst                   (rst),
      .decode_enable         (decode_enable),
      .baud_tick             (baud_tick),
      .infrared_receive_input(pin),
      .uart_rx               (uart_rx),
      .bit_valid             (bit_valid),
      .bit_data              (bit_data),
      .bit_ready             (bit_ready),
      .overrun               (overrun)
   );

   task automatic check(input string name, input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic t_reset();
      @(negedge sys_clk);
      check("uart_rx", uart_rx, 1'b1);
      check("bit_valid", bit_valid, 1'b0);
      check("overrun", overrun, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_frame();
      logic exp[6];
      int   i;
      exp = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      got.delete();
      fork
         for (i = 0; i < 5; i++)
            ird_ir_model_i.send_bit(exp[i]);
         begin
            // Pin falls within one tick of the start; the update comes eight ticks later.
            repeat (24) @(posedge sys_clk);
            #1 check("uart_rx before count 8", uart_rx, 1'b1);
            repeat (20) @(posedge sys_clk);
            #1 check("uart_rx after count 8", uart_rx, 1'b0);
         end
      join
      repeat (128) @(posedge sys_clk);
      check("bits out", got.size() >= 6, 1'b1);
      for (i = 0; i < 6 && i < got.size(); i++)
         check("bit_data", got[i], exp[i]);
      $display("test frame done");
   endtask

   task automatic t_fill();
      int i;
      bit_ready <= 1'b0;
      for (i = 0; i < 34; i++)
         ird_ir_model_i.send_bit(1'b0);
      repeat (64) @(posedge sys_clk);
      #1 check("overrun", overrun, 1'b1);
      @(posedge sys_clk);
      got.delete();
      bit_ready <= 1'b1;
      // The output stage hands over one bit every two cycles.
      repeat (80) @(posedge sys_clk);
      check("drained", got.size() >= 32, 1'b1);
      for (i = 0; i < 32 && i < got.size(); i++)
         check("fifo bit", got[i], 1'b0);
      check("overrun sticky", overrun, 1'b1);
      $display("test fill done");
   endtask

   task automatic t_disable();
      int i;
      do_reset();
      decode_enable <= 1'b0;
      for (i = 0; i < 3; i++) begin
         ird_ir_model_i.send_bit(1'b0);
         check("uart_rx disabled", uart_rx, 1'b1);
      end
      check("overrun cleared", overrun, 1'b0);
      decode_enable <= 1'b1;
      $display("test disable done");
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #2000000;
      num_errors++;
      test_done();
   end

   initial begin
      do_reset();
      t_reset();
      t_frame();
      t_fill();
      t_disable();
      test_done();
   end
endmodule

`default_nettype wire
